// [hw/lvl_regs_consts.svh]
// constants of the leveling and axi configuration register bank
// assumes inclusion by bare name; guarded against double inclusion
`ifndef LVL_REGS_CONSTS_SVH
`define LVL_REGS_CONSTS_SVH
// byte addresses of the thirteen registers
`define OFS_LVL_TIMING_A   32'h4000_D5A8
`define OFS_RD_DLY_LIM     32'h4000_D5AC
`define OFS_RD_GATE_LIM    32'h4000_D5B0
`define OFS_RD_RESP_TIME   32'h4000_D5B4
`define OFS_RD_RESP_MASK   32'h4000_D5B8
`define OFS_RD_EN_GATE     32'h4000_D5BC
`define OFS_GATE_EN        32'h4000_D5C0
`define OFS_RD_MAX_TIME    32'h4000_D5C4
`define OFS_RD_ERR_CNT     32'h4000_D5C8
`define OFS_RD_INTERVALS   32'h4000_D5CC
`define OFS_FIFO_INFO      32'h4000_D5D0
`define OFS_FUTURE         32'h4000_D5D4
`define OFS_HINT_EN        32'h4000_D5D8
// writable bits of each register
`define MSK_LVL_TIMING_A   32'hFFFF_FFFF
`define MSK_RD_DLY_LIM     32'h00FF_FFFF
`define MSK_RD_GATE_LIM    32'h03FF_FFFF
`define MSK_RD_RESP_TIME   32'hFFFF_FFFF
`define MSK_RD_RESP_MASK   32'h000F_FFFF
`define MSK_RD_EN_GATE     32'h010F_FFFF
`define MSK_GATE_EN        32'h0000_0101
`define MSK_RD_MAX_TIME    32'hFFFF_FFFF
`define MSK_RD_ERR_CNT     32'h0000_0F0F
`define MSK_RD_INTERVALS   32'hFFFF_FFFF
`define MSK_FIFO_INFO      32'h0100_0007
`define MSK_FUTURE         32'h011F_0101
`define MSK_HINT_EN        32'h0101_0101
// register count, reset word and indices
`define REG_COUNT          13
`define REG_RST            32'h0000_0000
`define IDX_NONE           5'h1F
`define IDX_ERR            5'h08
`define IDX_FIFO           5'h0A
`define IDX_FUTURE         5'h0B
`define IDX_HINT           5'h0C
// field positions and report values
`define LAT_LSB            0
`define DEPTH_LSB          8
`define PTR_LSB            16
`define MERGE_BIT          24
`define ERR_LSB            16
`define HINT_STRIDE        8
`define PTR_BITS_RST       8'h05
`define DEPTH_RST          8'h14
// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// [hw/lvl_regs_pkg.sv]
// types shared by the register bank, its bus slave and hint gate
// assumes the constants header is on the include path
`include "lvl_regs_consts.svh"
package lvl_regs_pkg;
  // one write taken from the bus
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_t;
  // bus slave state
  typedef struct packed {
    logic        aw_got;
    logic [31:0] awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } slv_state_t;
  // hint gate state
  typedef struct packed {
    logic [3:0] honored;
  } gate_state_t;
  // register bank state
  typedef struct packed {
    logic [`REG_COUNT-1:0][31:0] regs;
  } bank_state_t;
  // leveling settings toward the controller core
  typedef struct packed {
    logic [7:0]  read_level_load_time;
    logic [7:0]  read_level_delay_line_time;
    logic [7:0]  read_level_enable_time;
    logic [7:0]  write_level_load_time;
    logic [15:0] read_level_delay_limit;
    logic [7:0]  read_level_response_latency;
    logic [9:0]  read_level_read_spacing;
    logic [15:0] gate_level_delay_limit;
    logic [31:0] read_level_response_time;
    logic [19:0] read_level_lane_mask;
    logic        read_level_enable;
    logic [19:0] gate_level_lane_mask;
    logic        gate_preamble_check_enable;
    logic        gate_level_enable;
    logic [31:0] read_level_time_limit;
    logic [3:0]  gate_level_lane0_count;
    logic [3:0]  read_level_lane0_count;
    logic [15:0] gate_level_period;
    logic [15:0] read_level_period;
  } level_cfg_t;
endpackage : lvl_regs_pkg

// [hw/axil_slave.sv]
// axi4-lite slave front end: one write and one read at a time
// assumes the bank decodes addresses combinationally
`timescale 1ns/100ps
`include "lvl_regs_consts.svh"
module axil_slave (
  input  wire logic                 sys_clk,  // system clock
  input  wire logic                 rst_b,    // sync reset, low
  input  wire logic [31:0]          awaddr,   // write address
  input  wire logic                 awvalid,  // write address valid
  output logic                      awready,  // write address ready
  input  wire logic [31:0]          wdata,    // write data
  input  wire logic [3:0]           wstrb,    // byte strobes
  input  wire logic                 wvalid,   // write data valid
  output logic                      wready,   // write data ready
  output logic [1:0]                bresp,    // write response
  output logic                      bvalid,   // write response valid
  input  wire logic                 bready,   // write response ready
  input  wire logic [31:0]          araddr,   // read address
  input  wire logic                 arvalid,  // read address valid
  output logic                      arready,  // read address ready
  output logic [31:0]               rdata,    // read data
  output logic [1:0]                rresp,    // read response
  output logic                      rvalid,   // read data valid
  input  wire logic                 rready,   // read data ready
  output lvl_regs_pkg::wr_req_t     wr_req,   // write to apply
  output logic                      wr_fire,  // write pulse
  input  wire logic                 wr_ok,    // write address mapped
  output logic                      rd_fire,  // read pulse
  input  wire logic [31:0]          rd_word,  // read word for araddr
  input  wire logic                 rd_ok     // read address mapped
);
  lvl_regs_pkg::slv_state_t q, d;
  logic aw_hs;
  logic w_hs;
  // handshakes and combined write request
  always_comb begin
    awready = !q.aw_got && !q.bvalid;
    wready  = !q.w_got && !q.bvalid;
    arready = !q.rvalid;
    aw_hs   = awvalid && awready;
    w_hs    = wvalid && wready;
    rd_fire = arvalid && arready;
    wr_fire = (q.aw_got || aw_hs) && (q.w_got || w_hs) && !q.bvalid;
    wr_req.addr = q.aw_got ? q.awaddr : awaddr;
    wr_req.data = q.w_got ? q.wdata : wdata;
    wr_req.strb = q.w_got ? q.wstrb : wstrb;
    d = q;
    if (aw_hs) begin
      d.aw_got = 1'b1;
      d.awaddr = awaddr;
    end
    if (w_hs) begin
      d.w_got = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_word;
      d.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end
  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) q <= '0;
    else q <= d;
  end
  assign bvalid = q.bvalid;
  assign bresp  = q.bresp;
  assign rvalid = q.rvalid;
  assign rresp  = q.rresp;
  assign rdata  = q.rdata;
endmodule : axil_slave

// [hw/strobe_hint_gate.sv]
// per-port gate of the full-write-strobe hint
// assumes hints arrive synchronous to sys_clk
`timescale 1ns/100ps
module strobe_hint_gate #(
  parameter int PORTS = 4                  // number of axi ports
) (
  input  wire logic             sys_clk,   // system clock
  input  wire logic             rst_b,     // sync reset, low
  input  wire logic [PORTS-1:0] hint,      // full strobe hint in
  input  wire logic [PORTS-1:0] enable,    // per-port enables
  output logic [PORTS-1:0]      honored    // hint as used
);
  lvl_regs_pkg::gate_state_t q, d;
  // a hint counts only on an enabled port
  always_comb begin
    d = q;
    d.honored = hint & enable; // [R8]
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) q <= '0;
    else q <= d;
  end
  assign honored = q.honored;
  property p_hint_gated;
    @(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=> ((honored & ~$past(enable)) == '0);
  endproperty
  a_hint_gated: assert property (p_hint_gated) // [R8]
    else $error("hint passed on a disabled port");
endmodule : strobe_hint_gate

// [hw/dram_ctrl_leveling_axi_cfg_regs.sv]
// leveling, merge fifo report, write latency and hint enable registers
// assumes an axi4-lite master on sys_clk and hints synchronous to it
//
// Operation
// [R1] software leaves all leveling timing, mask and count fields at reset
// [R2] software keeps the optimized merge write enable bit at reset value
// [R3] software keeps future-use fields bit 24, 20:16 and bit 8 at reset
// [R4] software writes one into future-use bit 0 during setup
// [R5] merge fifo pointer width reads from a read-only field 23:16
// [R6] merge fifo depth reads from a read-only field 15:8
// [R7] writable three-bit write payload latency drives the phy side
// [R8] each port's strobe hint is used only when its enable is one
// [R9] read-only writes do nothing, reserved read-only bits read zero
`timescale 1ns/100ps
`include "lvl_regs_consts.svh"
module dram_ctrl_leveling_axi_cfg_regs #(
  parameter logic [7:0] PTR_BITS = `PTR_BITS_RST, // fifo pointer width
  parameter logic [7:0] DEPTH    = `DEPTH_RST     // fifo depth
) (
  input  wire logic                    sys_clk,   // system clock
  input  wire logic                    rst_b,     // sync reset, low
  input  wire logic [31:0]             awaddr,    // write address
  input  wire logic                    awvalid,   // write addr valid
  output logic                         awready,   // write addr ready
  input  wire logic [31:0]             wdata,     // write data
  input  wire logic [3:0]              wstrb,     // byte strobes
  input  wire logic                    wvalid,    // write data valid
  output logic                         wready,    // write data ready
  output logic [1:0]                   bresp,     // write response
  output logic                         bvalid,    // write resp valid
  input  wire logic                    bready,    // write resp ready
  input  wire logic [31:0]             araddr,    // read address
  input  wire logic                    arvalid,   // read addr valid
  output logic                         arready,   // read addr ready
  output logic [31:0]                  rdata,     // read data
  output logic [1:0]                   rresp,     // read response
  output logic                         rvalid,    // read data valid
  input  wire logic                    rready,    // read data ready
  input  wire logic [13:0]             read_level_error_flags, // core
  input  wire logic [3:0]              full_strobe_hint,    // per port
  output logic [3:0]                   full_strobe_honored, // gated
  output logic [2:0]                   phy_write_payload_latency, // phy
  output logic                         optimized_merge_write_enable,
  output logic [31:0]                  future_use_ctrl,     // raw word
  output lvl_regs_pkg::level_cfg_t     level_cfg            // leveling
);
  ////////////////////////////////////////////////////////////////////
  // decode and merge helpers
  function automatic logic [4:0] reg_index(input logic [31:0] a);
    case (a)
      `OFS_LVL_TIMING_A: reg_index = 5'h00;
      `OFS_RD_DLY_LIM:   reg_index = 5'h01;
      `OFS_RD_GATE_LIM:  reg_index = 5'h02;
      `OFS_RD_RESP_TIME: reg_index = 5'h03;
      `OFS_RD_RESP_MASK: reg_index = 5'h04;
      `OFS_RD_EN_GATE:   reg_index = 5'h05;
      `OFS_GATE_EN:      reg_index = 5'h06;
      `OFS_RD_MAX_TIME:  reg_index = 5'h07;
      `OFS_RD_ERR_CNT:   reg_index = `IDX_ERR;
      `OFS_RD_INTERVALS: reg_index = 5'h09;
      `OFS_FIFO_INFO:    reg_index = `IDX_FIFO;
      `OFS_FUTURE:       reg_index = `IDX_FUTURE;
      `OFS_HINT_EN:      reg_index = `IDX_HINT;
      default:           reg_index = `IDX_NONE;
    endcase
  endfunction : reg_index

  function automatic logic [31:0] wr_mask(input logic [4:0] i);
    case (i)
      5'h00:       wr_mask = `MSK_LVL_TIMING_A;
      5'h01:       wr_mask = `MSK_RD_DLY_LIM;
      5'h02:       wr_mask = `MSK_RD_GATE_LIM;
      5'h03:       wr_mask = `MSK_RD_RESP_TIME;
      5'h04:       wr_mask = `MSK_RD_RESP_MASK;
      5'h05:       wr_mask = `MSK_RD_EN_GATE;
      5'h06:       wr_mask = `MSK_GATE_EN;
      5'h07:       wr_mask = `MSK_RD_MAX_TIME;
      `IDX_ERR:    wr_mask = `MSK_RD_ERR_CNT;
      5'h09:       wr_mask = `MSK_RD_INTERVALS;
      `IDX_FIFO:   wr_mask = `MSK_FIFO_INFO;
      `IDX_FUTURE: wr_mask = `MSK_FUTURE;
      `IDX_HINT:   wr_mask = `MSK_HINT_EN;
      default:     wr_mask = 32'h0000_0000;
    endcase
  endfunction : wr_mask

  // byte strobes expanded to a bit mask
  function automatic logic [31:0] strb_bits(input logic [3:0] s);
    strb_bits = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_bits

  ////////////////////////////////////////////////////////////////////
  // bus front end
  lvl_regs_pkg::wr_req_t wr_req;
  logic        wr_fire;
  logic        rd_fire;
  logic [4:0]  wr_idx;
  logic [4:0]  rd_idx;
  logic [31:0] rd_word;
  logic [3:0]  hint_enable;

  axil_slave u_bus (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_req  (wr_req),
    .wr_fire (wr_fire),
    .wr_ok   (wr_idx != `IDX_NONE),
    .rd_fire (rd_fire),
    .rd_word (rd_word),
    .rd_ok   (rd_idx != `IDX_NONE)
  );

  ////////////////////////////////////////////////////////////////////
  // register state
  lvl_regs_pkg::bank_state_t q, d;

  // masked byte writes; read-only and reserved bits never stored
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    wr_idx = reg_index(wr_req.addr);
    d = q;
    for (int i = 0; i < `REG_COUNT; i++) begin
      if (wr_fire && wr_idx == 5'(i)) begin
        m = wr_mask(5'(i)) & strb_bits(wr_req.strb); // [R9]
        d.regs[i] = (q.regs[i] & ~m) | (wr_req.data & m); // [R7]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) q <= '0;
    else q <= d;
  end

  // read word: stored bits plus report fields and core status
  always_comb begin
    rd_idx  = reg_index(araddr);
    rd_word = 32'h0000_0000;
    if (rd_idx != `IDX_NONE) begin
      rd_word = q.regs[rd_idx[3:0]] & wr_mask(rd_idx); // [R9]
    end
    if (rd_idx == `IDX_FIFO) begin
      rd_word[`PTR_LSB +: 8]   = PTR_BITS; // [R5]
      rd_word[`DEPTH_LSB +: 8] = DEPTH; // [R6]
    end
    if (rd_idx == `IDX_ERR) begin
      rd_word[`ERR_LSB +: 14] = read_level_error_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // settings toward the controller and phy
  assign phy_write_payload_latency =
    q.regs[`IDX_FIFO][`LAT_LSB +: 3]; // [R7]
  assign optimized_merge_write_enable = q.regs[`IDX_FIFO][`MERGE_BIT];
  assign future_use_ctrl = q.regs[`IDX_FUTURE];

  // leveling fields, held but not interpreted here
  assign level_cfg.read_level_load_time        = q.regs[0][31:24];
  assign level_cfg.read_level_delay_line_time  = q.regs[0][23:16];
  assign level_cfg.read_level_enable_time      = q.regs[0][15:8];
  assign level_cfg.write_level_load_time       = q.regs[0][7:0];
  assign level_cfg.read_level_delay_limit      = q.regs[1][23:8];
  assign level_cfg.read_level_response_latency = q.regs[1][7:0];
  assign level_cfg.read_level_read_spacing     = q.regs[2][25:16];
  assign level_cfg.gate_level_delay_limit      = q.regs[2][15:0];
  assign level_cfg.read_level_response_time    = q.regs[3];
  assign level_cfg.read_level_lane_mask        = q.regs[4][19:0];
  assign level_cfg.read_level_enable           = q.regs[5][24];
  assign level_cfg.gate_level_lane_mask        = q.regs[5][19:0];
  assign level_cfg.gate_preamble_check_enable  = q.regs[6][8];
  assign level_cfg.gate_level_enable           = q.regs[6][0];
  assign level_cfg.read_level_time_limit       = q.regs[7];
  assign level_cfg.gate_level_lane0_count      = q.regs[8][11:8];
  assign level_cfg.read_level_lane0_count      = q.regs[8][3:0];
  assign level_cfg.gate_level_period           = q.regs[9][31:16];
  assign level_cfg.read_level_period           = q.regs[9][15:0];

  ////////////////////////////////////////////////////////////////////
  // full strobe hint enables and gate
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      hint_enable[p] = q.regs[`IDX_HINT][p * `HINT_STRIDE]; // [R8]
    end
  end

  strobe_hint_gate #(
    .PORTS (4)
  ) u_gate (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .hint    (full_strobe_hint),
    .enable  (hint_enable),
    .honored (full_strobe_honored)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_ptr_report;
    @(posedge sys_clk) disable iff (!rst_b)
      (rd_fire && reg_index(araddr) == `IDX_FIFO)
        |=> rvalid && rdata[`PTR_LSB +: 8] == PTR_BITS;
  endproperty
  a_ptr_report: assert property (p_ptr_report) // [R5]
    else $error("fifo pointer width misreported");

  property p_depth_report;
    @(posedge sys_clk) disable iff (!rst_b)
      (rd_fire && reg_index(araddr) == `IDX_FIFO)
        |=> rdata[`DEPTH_LSB +: 8] == DEPTH && rresp == `RESP_OKAY;
  endproperty
  a_depth_report: assert property (p_depth_report) // [R6]
    else $error("fifo depth misreported");

  property p_latency_write;
    @(posedge sys_clk) disable iff (!rst_b)
      (wr_fire && wr_idx == `IDX_FIFO && wr_req.strb[0])
        |=> phy_write_payload_latency == $past(wr_req.data[2:0]);
  endproperty
  a_latency_write: assert property (p_latency_write) // [R7]
    else $error("write latency not taken");

  property p_enable_write;
    @(posedge sys_clk) disable iff (!rst_b)
      (wr_fire && wr_idx == `IDX_HINT && wr_req.strb == 4'hF)
        |=> ##1 hint_enable == {$past(wr_req.data[24], 2),
          $past(wr_req.data[16], 2), $past(wr_req.data[8], 2),
          $past(wr_req.data[0], 2)};
  endproperty
  a_enable_write: assert property (p_enable_write) // [R8]
    else $error("hint enables not updated");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!rst_b)
      (rd_fire && reg_index(araddr) == `IDX_HINT)
        |=> (rdata & ~`MSK_HINT_EN) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R9]
    else $error("reserved bits read nonzero");
endmodule : dram_ctrl_leveling_axi_cfg_regs

// [testbench/hint_core_model.sv]
// far-side model: axi port hint sources and core leveling status
// assumes sys_clk and rst_b of the bench; status changes only on request
`timescale 1ns/100ps
module hint_core_model (
  input  wire logic        sys_clk,   // system clock
  input  wire logic        rst_b,     // sync reset, low
  input  wire logic        flag_step, // load new status flags
  output logic [3:0]       hint,      // full strobe hints
  output logic [13:0]      flags      // leveling error status
);
  int hint_seed = 21420;

  ////////////////////////////////////////////////////////////////////////////
  // time-zero values
  initial begin
    hint = 4'h0;
    flags = 14'h0000;
  end

  // hints toggle freely every cycle, status only when stepped
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      hint <= 4'h0;
    end else begin
      hint <= 4'($random(hint_seed));
      if (flag_step) flags <= 14'($random(hint_seed));
    end
  end
endmodule : hint_core_model

// [testbench/dram_ctrl_leveling_axi_cfg_regs_tb.sv]
// self-checking bench of the leveling and axi configuration registers
// assumes the design with default report parameters and its header
`timescale 1ns/100ps
`include "lvl_regs_consts.svh"
module dram_ctrl_leveling_axi_cfg_regs_tb;
  localparam logic [31:0] FIFO_REP = {8'h00, `PTR_BITS_RST, `DEPTH_RST, 8'h00};
  localparam logic [31:0] OFS [13] = '{`OFS_LVL_TIMING_A, `OFS_RD_DLY_LIM,
    `OFS_RD_GATE_LIM, `OFS_RD_RESP_TIME, `OFS_RD_RESP_MASK, `OFS_RD_EN_GATE,
    `OFS_GATE_EN, `OFS_RD_MAX_TIME, `OFS_RD_ERR_CNT, `OFS_RD_INTERVALS,
    `OFS_FIFO_INFO, `OFS_FUTURE, `OFS_HINT_EN};
  localparam logic [31:0] MSK [13] = '{`MSK_LVL_TIMING_A, `MSK_RD_DLY_LIM,
    `MSK_RD_GATE_LIM, `MSK_RD_RESP_TIME, `MSK_RD_RESP_MASK, `MSK_RD_EN_GATE,
    `MSK_GATE_EN, `MSK_RD_MAX_TIME, `MSK_RD_ERR_CNT, `MSK_RD_INTERVALS,
    `MSK_FIFO_INFO, `MSK_FUTURE, `MSK_HINT_EN};
  localparam logic [31:0] BAD [3] = '{32'h4000_D5DC, 32'h4000_D5A4, 32'h0000_D5D0};
  logic        sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, merge_en, flag_step;
  logic        hint_chk, hint_ok_q;
  logic [31:0] awaddr, wdata, araddr, rdata, future_w, en_exp, wv;
  logic [3:0]  wstrb, hint_w, honored, hint_prev, en_prev;
  logic [1:0]  bresp, rresp;
  logic [2:0]  lat_w;
  logic [13:0] flags_w;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [33:0] rexp;
  lvl_regs_pkg::level_cfg_t lvl_w;
  int          fails = 0;
  int          compares = 0;
  int          seed = 21420;

  ////////////////////////////////////////////////////////////////////////////
  // design, far-side model and clock
  dram_ctrl_leveling_axi_cfg_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .read_level_error_flags(flags_w),
    .full_strobe_hint(hint_w), .full_strobe_honored(honored),
    .phy_write_payload_latency(lat_w), .optimized_merge_write_enable(merge_en),
    .future_use_ctrl(future_w), .level_cfg(lvl_w));
  hint_core_model partner_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .flag_step(flag_step), .hint(hint_w), .flags(flags_w));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and verdict tasks
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected resp at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_resp
  task automatic cmp_hint(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected hint at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_hint
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // expected read word: stored bits plus read-only report fields
  function automatic logic [31:0] exp_of(input int i, input logic [31:0] st);
    if (i == `IDX_ERR) return st | {2'b00, flags_w, 16'h0000};
    if (i == `IDX_FIFO) return st | FIFO_REP;
    return st;
  endfunction : exp_of

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master cycles, each note queued for the watcher
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    @(posedge sys_clk);
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge sys_clk);
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  // watcher: bus answers against the oldest note
  always @(posedge sys_clk) begin
    if (bvalid === 1'b1 && bready) cmp_resp(bresp, bq.pop_front());
    if (rvalid === 1'b1 && rready) begin
      rexp = rq.pop_front();
      cmp_resp(rresp, rexp[33:32]);
      cmp_word(rdata, rexp[31:0]);
    end
  end

  // watcher: honored hint is last hint gated by the enables
  always @(negedge sys_clk) begin
    if (hint_ok_q) cmp_hint(honored, hint_prev & en_prev);
    hint_prev = hint_w;
    en_prev = {en_exp[24], en_exp[16], en_exp[8], en_exp[0]};
    hint_ok_q = hint_chk && rst_b;
  end

  // watchdog
  initial begin
    repeat (8000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, flag_step} = 7'h00;
    {awaddr, wdata, araddr, wstrb} = 100'h0;
    {hint_chk, hint_ok_q, en_exp, wv} = 66'h0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    hint_chk <= 1'b1;
    flag_step <= 1'b1;
    @(posedge sys_clk);
    flag_step <= 1'b0;
    // reset values, then reserved bits set while writable bits keep reset except future-use bit 0 set to one
    for (int i = 0; i < 13; i++) begin
      axi_rd(OFS[i], exp_of(i, 32'h0), `RESP_OKAY);
      wv = ~MSK[i] | 32'(i == `IDX_FUTURE);
      axi_wr(OFS[i], wv, 4'hF, `RESP_OKAY);
      axi_rd(OFS[i], exp_of(i, wv & MSK[i]), `RESP_OKAY);
    end
    cmp_word(future_w, 32'h0000_0001);
    cmp_word({31'h0, merge_en}, 32'h0);
    cmp_word({31'h0, |lvl_w}, 32'h0);
    // every write latency value, then a write with no strobes
    for (int v = 0; v < 8; v++) begin
      axi_wr(`OFS_FIFO_INFO, 32'(v), 4'h1, `RESP_OKAY);
      cmp_word({29'h0, lat_w}, 32'(v));
    end
    axi_wr(`OFS_FIFO_INFO, 32'h0000_0002, 4'h0, `RESP_OKAY);
    axi_rd(`OFS_FIFO_INFO, FIFO_REP | 32'h7, `RESP_OKAY);
    // every enable pattern with random reserved bits and live hints
    for (int p = 0; p < 16; p++) begin
      wv = 32'($random(seed)) & ~`MSK_HINT_EN;
      wv = wv | {7'h0, p[3], 7'h0, p[2], 7'h0, p[1], 7'h0, p[0]};
      hint_chk <= 1'b0;
      axi_wr(`OFS_HINT_EN, wv, 4'hF, `RESP_OKAY);
      en_exp <= wv & `MSK_HINT_EN;
      repeat (2) @(posedge sys_clk);
      hint_chk <= 1'b1;
      repeat (10) @(posedge sys_clk);
      axi_rd(`OFS_HINT_EN, wv & `MSK_HINT_EN, `RESP_OKAY);
    end
    // unmapped and aliased addresses refuse and change nothing
    for (int b = 0; b < 3; b++) begin
      axi_wr(BAD[b], 32'hFFFF_FFFF, 4'hF, `RESP_SLVERR);
      axi_rd(BAD[b], 32'h0, `RESP_SLVERR);
    end
    axi_rd(`OFS_FIFO_INFO, FIFO_REP | 32'h7, `RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule : dram_ctrl_leveling_axi_cfg_regs_tb
